//--- dscg_pkg.sv
// constants and types for the deep-sleep clock gate controller
// assumes an APB master on the system clock and a power manager driving state requests
//
// Functional notes
// [R1] a set gating bit clocks its unit; a clear bit leaves it unclocked, disabled
// [R2] access to a unit whose clock is gated is answered with a bus fault
// [R3] every gating bit resets to zero, whole register reads 0x00000000
// [R4] separate run, sleep and deep-sleep gate registers, chosen by power state
// [R5] sleep and deep-sleep registers apply only when auto clock gating is set
// [R6] bit 30 PHY, bit 28 MAC, bits 6..0 ports G..A, all read-write
// [R7] bits 31, 29 and 27..7 read zero and ignore writes
// [R8] software preserves reserved bits on read-modify-write, never relies on them
// [R9] software must set the gate of every unit it needs
// [R10] deep-sleep register sits at base plus 0x128, 32 bits wide
// [R11] enable changes must not truncate or glitch the gated unit clock
package dscg_pkg;

  localparam logic [31:0] SYSCTL_BASE     = 32'h400FE000;
  localparam logic [31:0] ADDR_RUN_CONFIG = SYSCTL_BASE + 32'h00000020;
  localparam logic [31:0] ADDR_RUN_GATE   = SYSCTL_BASE + 32'h00000100;
  localparam logic [31:0] ADDR_SLEEP_GATE = SYSCTL_BASE + 32'h00000110;
  localparam logic [31:0] ADDR_DEEP_GATE  = SYSCTL_BASE + 32'h00000128;

  localparam logic [31:0] GATE_RESET      = 32'h00000000;
  localparam logic [31:0] GATE_WRITE_MASK = 32'h5000007F;
  localparam logic        CONFIG_RESET    = 1'b0;
  localparam int          ACG_BIT         = 0;

  localparam int NUM_UNITS = 9;
  // unit index: 0..6 ports A..G, 7 MAC, 8 PHY
  localparam int UNIT_BIT [NUM_UNITS] = '{0, 1, 2, 3, 4, 5, 6, 28, 30};

  typedef enum logic [1:0] {
    PS_RUN,
    PS_SLEEP,
    PS_DEEP
  } dscg_power_type;

endpackage

//--- dscg_unit_gate.sv
// one gated unit: registered clock enable and bus fault check
// assumes the unit's own bus presents a one-cycle access pulse
`timescale 1ns/1ps
module dscg_unit_gate (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // gate request from the selected register
  input  wire logic gate_open,
  // unit access
  input  wire logic access_req,
  output logic      clk_en,
  output logic      access_fault,
  output logic      access_grant
);

  typedef struct packed {
    logic clk_en;
    logic fault;
    logic grant;
  } dscg_unit_state_type;

  dscg_unit_state_type state;
  dscg_unit_state_type next_state;

  always_comb begin
    next_state = state;
    // enable only moves on a clock edge, so the unit sees whole cycles
    next_state.clk_en = gate_open; // [R1] [R11]
    // judge against the enable the unit actually has this cycle
    next_state.fault = access_req && !state.clk_en; // [R2]
    next_state.grant = access_req && state.clk_en;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= '0; // [R3]
    end else begin
      state <= next_state;
    end
  end

  assign clk_en       = state.clk_en;
  assign access_fault = state.fault;
  assign access_grant = state.grant;

  gated_fault_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
    (access_req && !clk_en) |=> (access_fault && !access_grant))
    else $error("access to gated unit not faulted");

  enable_steady_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R11]
    $changed(clk_en) |-> (clk_en == $past(gate_open)))
    else $error("clock enable moved without gate request");

endmodule

//--- dscg_ctrl.sv
// clock gate controller: run, sleep and deep-sleep gate registers on APB
// assumes APB3 master on clk_sys; power state requests are synchronous levels
`timescale 1ns/1ps
module dscg_ctrl (
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // power manager
  input  wire logic                            sleep_request,
  input  wire logic                            deep_request,
  // gated units
  input  wire logic [dscg_pkg::NUM_UNITS-1:0]  unit_access,
  output logic      [dscg_pkg::NUM_UNITS-1:0]  unit_clk_en,
  output logic      [dscg_pkg::NUM_UNITS-1:0]  unit_fault,
  output logic      [dscg_pkg::NUM_UNITS-1:0]  unit_grant
);

  typedef struct packed {
    logic [31:0]              run_gate;
    logic [31:0]              sleep_gate;
    logic [31:0]              deep_gate;
    logic                     auto_clock_gating_select;
    dscg_pkg::dscg_power_type pstate;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } dscg_ctrl_state_type;

  dscg_ctrl_state_type state;
  dscg_ctrl_state_type next_state;

  logic                           access_open;
  logic                           access_done;
  logic                           hit_run;
  logic                           hit_sleep;
  logic                           hit_deep;
  logic                           hit_cfg;
  logic                           hit_any;
  logic [31:0]                    read_word;
  logic [31:0]                    sel_gate;
  logic [dscg_pkg::NUM_UNITS-1:0] gate_open;

  function automatic logic [dscg_pkg::NUM_UNITS-1:0] unit_bits(input logic [31:0] word);
    logic [dscg_pkg::NUM_UNITS-1:0] bits;
    bits = '0;
    for (int i = 0; i < dscg_pkg::NUM_UNITS; i++) begin
      bits[i] = word[dscg_pkg::UNIT_BIT[i]]; // [R6]
    end
    return bits;
  endfunction

  // first access cycle takes the decode, the second one completes
  assign access_open = psel && penable && !state.pready;
  assign access_done = psel && penable && state.pready;

  assign hit_run   = (paddr == dscg_pkg::ADDR_RUN_GATE);
  assign hit_sleep = (paddr == dscg_pkg::ADDR_SLEEP_GATE);
  assign hit_deep  = (paddr == dscg_pkg::ADDR_DEEP_GATE); // [R10]
  assign hit_cfg   = (paddr == dscg_pkg::ADDR_RUN_CONFIG);
  assign hit_any   = hit_run || hit_sleep || hit_deep || hit_cfg;

  always_comb begin
    read_word = 32'h00000000;
    if (hit_run) begin
      read_word = state.run_gate;
    end else if (hit_sleep) begin
      read_word = state.sleep_gate;
    end else if (hit_deep) begin
      read_word = state.deep_gate & dscg_pkg::GATE_WRITE_MASK; // [R7]
    end else if (hit_cfg) begin
      read_word[dscg_pkg::ACG_BIT] = state.auto_clock_gating_select;
    end
  end

  // without auto gating the run register rules in every power state
  always_comb begin
    sel_gate = state.run_gate;
    if (state.auto_clock_gating_select) begin // [R5]
      case (state.pstate)
        dscg_pkg::PS_RUN: begin
          sel_gate = state.run_gate;
        end
        dscg_pkg::PS_SLEEP: begin
          sel_gate = state.sleep_gate; // [R4]
        end
        dscg_pkg::PS_DEEP: begin
          sel_gate = state.deep_gate; // [R4]
        end
        default: begin
          sel_gate = state.run_gate;
        end
      endcase
    end
  end

  assign gate_open = unit_bits(sel_gate); // [R1]

  always_comb begin
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (access_open) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !hit_any;
      next_state.prdata = read_word;
    end
    // writes land only at the completing edge
    if (access_done && pwrite && !state.pslverr) begin
      if (hit_run) begin
        next_state.run_gate = pwdata & dscg_pkg::GATE_WRITE_MASK; // [R7]
      end
      if (hit_sleep) begin
        next_state.sleep_gate = pwdata & dscg_pkg::GATE_WRITE_MASK; // [R7]
      end
      if (hit_deep) begin
        next_state.deep_gate = pwdata & dscg_pkg::GATE_WRITE_MASK; // [R6] [R7] [R10]
      end
      if (hit_cfg) begin
        next_state.auto_clock_gating_select = pwdata[dscg_pkg::ACG_BIT];
      end
    end
    // deep request wins over sleep; state tracks requests each cycle
    case (state.pstate)
      dscg_pkg::PS_RUN,
      dscg_pkg::PS_SLEEP,
      dscg_pkg::PS_DEEP: begin
        if (deep_request) begin
          next_state.pstate = dscg_pkg::PS_DEEP;
        end else if (sleep_request) begin
          next_state.pstate = dscg_pkg::PS_SLEEP;
        end else begin
          next_state.pstate = dscg_pkg::PS_RUN;
        end
      end
      default: begin
        next_state.pstate = dscg_pkg::PS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state.run_gate   <= dscg_pkg::GATE_RESET; // [R3]
      state.sleep_gate <= dscg_pkg::GATE_RESET; // [R3]
      state.deep_gate  <= dscg_pkg::GATE_RESET; // [R3]
      state.auto_clock_gating_select        <= dscg_pkg::CONFIG_RESET;
      state.pstate     <= dscg_pkg::PS_RUN;
      state.pready     <= 1'b0;
      state.pslverr    <= 1'b0;
      state.prdata     <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;

  genvar gi;
  generate
    for (gi = 0; gi < dscg_pkg::NUM_UNITS; gi++) begin : g_unit
      dscg_unit_gate u_gate (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .gate_open    (gate_open[gi]),
        .access_req   (unit_access[gi]),
        .clk_en       (unit_clk_en[gi]),
        .access_fault (unit_fault[gi]),
        .access_grant (unit_grant[gi])
      ); // [R1] [R2]
    end
  endgenerate

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence first_access_s;
    psel && penable && !pready;
  endsequence

  sequence deep_write_s;
    psel && penable && pready && pwrite && hit_deep;
  endsequence

  sequence complete_s;
    psel && penable && pready;
  endsequence

  sequence cfg_write_s;
    psel && penable && pready && pwrite && hit_cfg;
  endsequence

  // reset state: every gate closed, auto gating off, run state
  reset_clear_a: assert property ( // [R3]
    !$past(reset_n) |-> (state.deep_gate == 32'h00000000 && unit_clk_en == '0))
    else $error("gates not clear after reset");

  reset_regs_a: assert property ( // [R3]
    !$past(reset_n) |-> (state.run_gate == 32'h00000000 && state.sleep_gate == 32'h00000000
      && !state.auto_clock_gating_select && state.pstate == dscg_pkg::PS_RUN))
    else $error("registers not clear after reset");

  // bus timing: always one wait state, answer stands a single cycle
  wait_state_a: assert property ( // [R10]
    setup_s ##1 first_access_s |=> pready)
    else $error("apb answer not one wait state");

  pready_pulse_a: assert property ( // [R10]
    complete_s |=> !pready)
    else $error("pready held past one cycle");

  pslverr_ready_a: assert property (
    pslverr |-> pready)
    else $error("slave error without ready");

  deep_write_a: assert property ( // [R6]
    deep_write_s |=> (state.deep_gate == ($past(pwdata) & 32'h5000007F)))
    else $error("deep gate write wrong");

  // the deep register moves only on a completed write to its own address
  deep_hold_a: assert property ( // [R10]
    !(psel && penable && pready && pwrite && hit_deep) |=> $stable(state.deep_gate))
    else $error("deep gate changed without a write");

  run_write_a: assert property ( // [R7]
    complete_s ##0 (pwrite && hit_run)
      |=> (state.run_gate == ($past(pwdata) & dscg_pkg::GATE_WRITE_MASK)))
    else $error("run gate write wrong");

  sleep_write_a: assert property ( // [R7]
    complete_s ##0 (pwrite && hit_sleep)
      |=> (state.sleep_gate == ($past(pwdata) & dscg_pkg::GATE_WRITE_MASK)))
    else $error("sleep gate write wrong");

  acg_write_a: assert property ( // [R5]
    cfg_write_s |=> (state.auto_clock_gating_select == $past(pwdata[dscg_pkg::ACG_BIT])))
    else $error("auto gating bit write wrong");

  reserved_zero_a: assert property ( // [R7]
    first_access_s ##0 hit_deep |=> ((prdata & 32'hAFFFFF80) == 32'h00000000))
    else $error("reserved deep gate bits read nonzero");

  deep_read_a: assert property ( // [R10]
    first_access_s ##0 (hit_deep && !pwrite)
      |=> (pready && !pslverr && prdata == $past(state.deep_gate)))
    else $error("deep gate read back wrong");

  reserved_kept_a: assert property ( // [R7]
    (state.deep_gate & ~dscg_pkg::GATE_WRITE_MASK) == 32'h00000000)
    else $error("reserved deep gate bits stored");

  unmapped_err_a: assert property (
    first_access_s ##0 !hit_any |=> (pready && pslverr))
    else $error("unmapped access not refused");

  // register selection by power state and auto gating
  run_select_a: assert property ( // [R5]
    (!state.auto_clock_gating_select || state.pstate == dscg_pkg::PS_RUN)
      |-> (gate_open == unit_bits(state.run_gate)))
    else $error("run gate not selected");

  sleep_select_a: assert property ( // [R4]
    (state.auto_clock_gating_select && state.pstate == dscg_pkg::PS_SLEEP)
      |-> (gate_open == unit_bits(state.sleep_gate)))
    else $error("sleep gate not selected in sleep");

  deep_select_a: assert property ( // [R4]
    (state.auto_clock_gating_select && state.pstate == dscg_pkg::PS_DEEP)
      |-> (gate_open == unit_bits(state.deep_gate)))
    else $error("deep gate not selected in deep sleep");

  // power state follows the request levels one edge later
  deep_track_a: assert property ( // [R4]
    deep_request |=> (state.pstate == dscg_pkg::PS_DEEP))
    else $error("deep request not followed");

  sleep_track_a: assert property ( // [R4]
    (sleep_request && !deep_request) |=> (state.pstate == dscg_pkg::PS_SLEEP))
    else $error("sleep request not followed");

  run_track_a: assert property ( // [R4]
    (!sleep_request && !deep_request) |=> (state.pstate == dscg_pkg::PS_RUN))
    else $error("run state not resumed");

  // unit side: enables, faults and grants
  enable_follow_a: assert property ( // [R1]
    ##1 (unit_clk_en == $past(gate_open)))
    else $error("unit clock enable lags gate");

  fault_map_a: assert property ( // [R2]
    (unit_access & ~unit_clk_en) != '0 |=> (unit_fault == $past(unit_access & ~unit_clk_en)))
    else $error("fault not raised for gated unit");

  grant_map_a: assert property ( // [R1]
    (unit_access & unit_clk_en) != '0 |=> (unit_grant == $past(unit_access & unit_clk_en)))
    else $error("grant not raised for clocked unit");

  grant_open_a: assert property ( // [R2]
    1'b1 |=> ((unit_grant & ~$past(unit_clk_en)) == '0))
    else $error("grant given to gated unit");

  access_quiet_a: assert property ( // [R2]
    unit_access == '0 |=> (unit_fault == '0 && unit_grant == '0))
    else $error("fault or grant without access");

endmodule

//--- tb.sv
// self-checking bench for the deep-sleep clock gate controller
// assumes dscg_pkg and dscg_ctrl are compiled first; bench acts as APB master
`timescale 1ns/1ps
module tb;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        sleep_request, deep_request, err;
  logic [31:0] paddr, pwdata, prdata, rd, rv, sv, dv;
  logic [8:0]  unit_access, unit_clk_en, unit_fault, unit_grant, msk, en;
  int          num_errors, tests_run;
  logic [31:0] regs [4] = '{dscg_pkg::ADDR_RUN_CONFIG, dscg_pkg::ADDR_RUN_GATE,
                            dscg_pkg::ADDR_SLEEP_GATE, dscg_pkg::ADDR_DEEP_GATE};

  dscg_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_request(sleep_request), .deep_request(deep_request),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault),
    .unit_grant(unit_grant));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one idle cycle before each setup keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // pready and data are read at the rising edge, before that edge's update lands
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready wait", {31'h0, pready}, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [8:0] units(input logic [31:0] r);
    return {r[30], r[28], r[6:0]};
  endfunction

  function automatic logic [8:0] pick(input int i, input logic [31:0] r, s, d);
    if (i % 2 == 0 || i % 3 == 0) return units(r);
    return (i % 3 == 1) ? units(s) : units(d);
  endfunction

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; sleep_request = 1'b0; deep_request = 1'b0;
    unit_access = 9'h000;
    void'($urandom(98638));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (regs[k]) begin
      apb(1'b0, regs[k], 32'h0);
      chk("reset value", rd, 32'h00000000);
    end
    @(negedge clk_sys);
    chk("reset clk_en", {23'h0, unit_clk_en}, 32'h0);
    $display("test reset done");
    apb(1'b1, dscg_pkg::ADDR_DEEP_GATE, 32'hFFFFFFFF);
    apb(1'b0, dscg_pkg::ADDR_DEEP_GATE, 32'h0);
    chk("deep all ones", rd, 32'h5000007F);
    apb(1'b1, dscg_pkg::ADDR_DEEP_GATE + 32'h4, 32'h0);
    chk("unmapped write err", {31'h0, err}, 32'h1);
    apb(1'b0, dscg_pkg::ADDR_DEEP_GATE + 32'h4, 32'h0);
    chk("unmapped read data", rd, 32'h0);
    apb(1'b0, dscg_pkg::ADDR_DEEP_GATE, 32'h0);
    chk("deep kept", rd, 32'h5000007F);
    chk("deep read err", {31'h0, err}, 32'h0);
    // read-modify-write: the reserved field goes back exactly as it was read
    apb(1'b1, dscg_pkg::ADDR_DEEP_GATE, rd & 32'hFFFFFFFE);
    apb(1'b0, dscg_pkg::ADDR_DEEP_GATE, 32'h0);
    chk("deep rmw", rd, 32'h5000007E);
    $display("test mask and decode done");
    for (int i = 0; i < 12; i++) begin
      rv = $urandom;
      sv = $urandom;
      dv = $urandom;
      apb(1'b1, dscg_pkg::ADDR_RUN_GATE, rv);
      apb(1'b1, dscg_pkg::ADDR_SLEEP_GATE, sv);
      apb(1'b1, dscg_pkg::ADDR_DEEP_GATE, dv);
      apb(1'b1, dscg_pkg::ADDR_RUN_CONFIG, {$urandom % 2 == 1, 30'h0, i % 2 == 1});
      apb(1'b0, dscg_pkg::ADDR_SLEEP_GATE, 32'h0);
      chk("sleep readback", rd, sv & 32'h5000007F);
      apb(1'b0, dscg_pkg::ADDR_RUN_CONFIG, 32'h0);
      chk("acg readback", rd, {31'h0, i % 2 == 1});
      sleep_request <= (i % 3 == 1) || (i % 3 == 2 && $urandom % 2 == 1);
      deep_request  <= (i % 3 == 2);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      en = pick(i, rv, sv, dv);
      chk("clk_en select", {23'h0, unit_clk_en}, {23'h0, en});
      msk = (i == 0) ? 9'h1FF : 9'($urandom);
      @(posedge clk_sys);
      unit_access <= msk;
      @(posedge clk_sys);
      unit_access <= 9'h000;
      @(negedge clk_sys);
      chk("unit fault", {23'h0, unit_fault}, {23'h0, msk & ~en});
      chk("unit grant", {23'h0, unit_grant}, {23'h0, msk & en});
    end
    $display("test gating and faults done");
    // second reset in mid-run, with gates open and requests still applied
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, dscg_pkg::ADDR_DEEP_GATE, 32'h0);
    chk("deep after reset", rd, 32'h00000000);
    @(negedge clk_sys);
    chk("clk_en after reset", {23'h0, unit_clk_en}, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
